/* pkg/fws_pkg.sv */
// Purpose: Constants for the flash write-status polling controller
// Assumes: 40 MHz pclk, APB slave for software, byte-wide flash bus
// Notes:   Register offsets are byte addresses of aligned words
`default_nettype none
package fws_pkg;
   // Register map
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_ADDR   = 8'h08;
   localparam logic [7:0] OFS_DATA   = 8'h0c;
   // Control bit positions
   localparam int CTRL_START  = 0;
   localparam int CTRL_WRITE  = 1;
   localparam int CTRL_POLL   = 2;
   // Status bit positions
   localparam int ST_BUSY     = 0;
   localparam int ST_DONE     = 1;
   localparam int ST_FAIL     = 2;
   localparam int ST_WINDOW   = 3;
   localparam int ST_TOGGLE   = 4;
   localparam int ST_DATA_LSB = 8;
   // Data bit positions of the status byte
   localparam int TOGGLE_POS  = 6;
   localparam int FAIL_POS    = 5;
   localparam int WINDOW_POS  = 3;
   // Strobe timing: each flash bus phase lasts this many ns
   localparam int CLK_NS      = 25;
   localparam int PHASE_NS    = 100;
   localparam int PHASE_CYC   = (PHASE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] PHASE_CYC_W = 4'(PHASE_CYC);
   localparam logic [31:0] RESET_CMD  = 32'h000000f0;
   // Controller states, Gray from FWS_IDLE through FWS_EVAL; not on the return from FWS_EVAL
   typedef enum logic [2:0] {
      FWS_IDLE  = 3'b000,
      FWS_SETUP = 3'b001,
      FWS_STRB  = 3'b011,
      FWS_HOLD  = 3'b010,
      FWS_EVAL  = 3'b110,
      FWS_RST   = 3'b111
   } fws_state_e;
endpackage : fws_pkg
`default_nettype wire

/* logic/fws_ctrl.sv */
// Purpose: Host controller that writes and reads a parallel flash and
//          runs the toggle-bit status check on completion of an operation
// Assumes: Flash data inputs are asynchronous and pass two flops
// Notes:   Reads are framed by output enable inside a chip-enable frame
// Behaviour
// - Read cycles framed by output or chip enable
// - Host starts with two back-to-back reads
// - Stopped toggle means done; next read valid
// - Toggling with fail bit: recheck, then decide
// - Interrupted check restarts from double read
// - Host issues reset after fail bit
// - Skip window check only under 50 us spacing
// - Check window bit around extra erase commands
// - Poll at program or erased-sector address
`timescale 1ns/100ps
`default_nettype none
module fws_ctrl #(
   parameter int AW = 17
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   output logic      [AW-1:0] flash_addr,
   input  wire logic [7:0]    flash_dq_in,
   output logic      [7:0]    flash_dq_out,
   output logic               flash_dq_oe,
   output logic               flash_ce_n,
   output logic               flash_oe_n,
   output logic               flash_we_n
);
   fws_pkg::fws_state_e state_r, state_nxt;
   logic [3:0]    cnt_r, cnt_nxt;
   logic [AW-1:0] addr_r, addr_nxt;
   logic [7:0]    wdat_r, wdat_nxt;
   logic [7:0]    rdat_r, rdat_nxt;
   logic          wr_r, wr_nxt, poll_r, poll_nxt;
   logic          busy_r, busy_nxt, done_r, done_nxt, fail_r, fail_nxt;
   logic          win_r, win_nxt, tog_r, tog_nxt;
   logic [1:0]    nrd_r, nrd_nxt;
   logic          failseen_r, failseen_nxt, rstcmd_r, rstcmd_nxt;
   logic [7:0]    dq_s1_r, dq_s2_r;
   logic [31:0]   prdata_nxt;
   logic          apb_wr, apb_rd;

   // Two-flop synchroniser on the asynchronous data pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dq_s1_r <= 8'h00;
         dq_s2_r <= 8'h00;
      end else begin
         dq_s1_r <= flash_dq_in;
         dq_s2_r <= dq_s1_r;
      end
   end

   // APB strobes; slave always answers in the access cycle
   assign apb_wr = psel && penable && pwrite;
   assign apb_rd = psel && !penable && !pwrite;

   // Read mux, registered so prdata is ready at the access phase
   always_comb begin
      prdata_nxt = prdata;
      if (apb_rd) begin
         if (paddr == fws_pkg::OFS_STATUS) begin
            prdata_nxt = 32'h0;
            prdata_nxt[fws_pkg::ST_BUSY]   = busy_r;
            prdata_nxt[fws_pkg::ST_DONE]   = done_r;
            prdata_nxt[fws_pkg::ST_FAIL]   = fail_r;
            prdata_nxt[fws_pkg::ST_WINDOW] = win_r;
            prdata_nxt[fws_pkg::ST_TOGGLE] = tog_r;
            prdata_nxt[fws_pkg::ST_DATA_LSB +: 8] = rdat_r;
         end else if (paddr == fws_pkg::OFS_ADDR) begin
            prdata_nxt = 32'(addr_r);
         end else if (paddr == fws_pkg::OFS_DATA) begin
            prdata_nxt = {24'h0, wdat_r};
         end else begin
            prdata_nxt = 32'h0;
         end
      end
   end

   // Sequencer next state: single bus cycles and the toggle check
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      addr_nxt = addr_r;
      wdat_nxt = wdat_r;
      rdat_nxt = rdat_r;
      wr_nxt = wr_r;
      poll_nxt = poll_r;
      busy_nxt = busy_r;
      done_nxt = done_r;
      fail_nxt = fail_r;
      win_nxt = win_r;
      tog_nxt = tog_r;
      nrd_nxt = nrd_r;
      failseen_nxt = failseen_r;
      rstcmd_nxt = rstcmd_r;
      if (apb_wr && !busy_r) begin
         if (paddr == fws_pkg::OFS_ADDR) begin
            addr_nxt = pwdata[AW-1:0];
         end else if (paddr == fws_pkg::OFS_DATA) begin
            wdat_nxt = pwdata[7:0];
         end
      end
      case (state_r)
         fws_pkg::FWS_IDLE: begin
            if (apb_wr && paddr == fws_pkg::OFS_CTRL && pwdata[fws_pkg::CTRL_START]) begin
               wr_nxt = pwdata[fws_pkg::CTRL_WRITE];
               poll_nxt = pwdata[fws_pkg::CTRL_POLL];
               busy_nxt = 1'b1;
               done_nxt = 1'b0;
               fail_nxt = 1'b0;
               nrd_nxt = 2'd0;
               failseen_nxt = 1'b0;
               rstcmd_nxt = 1'b0;
               cnt_nxt = fws_pkg::PHASE_CYC_W;
               state_nxt = fws_pkg::FWS_SETUP;
            end
         end
         fws_pkg::FWS_SETUP: begin
            cnt_nxt = cnt_r - 4'd1;
            if (cnt_r == 4'd1) begin
               cnt_nxt = fws_pkg::PHASE_CYC_W;
               state_nxt = fws_pkg::FWS_STRB;
            end
         end
         fws_pkg::FWS_STRB: begin
            // Strobe low; each read is a separate chip-enable frame
            cnt_nxt = cnt_r - 4'd1;
            if (cnt_r == 4'd1) begin
               if (!wr_r) begin
                  rdat_nxt = dq_s2_r;
               end
               cnt_nxt = fws_pkg::PHASE_CYC_W;
               state_nxt = fws_pkg::FWS_HOLD;
            end
         end
         fws_pkg::FWS_HOLD: begin
            cnt_nxt = cnt_r - 4'd1;
            if (cnt_r == 4'd1) begin
               state_nxt = fws_pkg::FWS_EVAL;
            end
         end
         fws_pkg::FWS_EVAL: begin
            cnt_nxt = fws_pkg::PHASE_CYC_W;
            if (!poll_r || rstcmd_r) begin
               busy_nxt = 1'b0;
               done_nxt = 1'b1;
               state_nxt = fws_pkg::FWS_IDLE;
            end else if (wr_r) begin
               // Command written; status check reads follow
               wr_nxt = 1'b0;
               state_nxt = fws_pkg::FWS_SETUP;
            end else if (nrd_r == 2'd0) begin
               tog_nxt = rdat_r[fws_pkg::TOGGLE_POS];
               nrd_nxt = 2'd1;
               state_nxt = fws_pkg::FWS_SETUP;
            end else if (tog_r == rdat_r[fws_pkg::TOGGLE_POS]) begin
               // Stopped: success even if the fail bit was seen, next read is data
               win_nxt = rdat_r[fws_pkg::WINDOW_POS];
               nrd_nxt = 2'd0;
               poll_nxt = 1'b0;
               state_nxt = fws_pkg::FWS_SETUP;
            end else if (failseen_r) begin
               // Still toggling after fail bit: failed, send reset
               fail_nxt = 1'b1;
               rstcmd_nxt = 1'b1;
               wr_nxt = 1'b1;
               wdat_nxt = fws_pkg::RESET_CMD[7:0];
               state_nxt = fws_pkg::FWS_SETUP;
            end else begin
               // Toggling; note fail bit and recheck
               failseen_nxt = rdat_r[fws_pkg::FAIL_POS];
               tog_nxt = rdat_r[fws_pkg::TOGGLE_POS];
               win_nxt = rdat_r[fws_pkg::WINDOW_POS];
               state_nxt = fws_pkg::FWS_SETUP;
            end
         end
         default: begin
            state_nxt = fws_pkg::FWS_IDLE;
         end
      endcase
   end

   // State registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= fws_pkg::FWS_IDLE;
         cnt_r <= 4'd0;
         addr_r <= '0;
         wdat_r <= 8'h00;
         rdat_r <= 8'h00;
         wr_r <= 1'b0;
         poll_r <= 1'b0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         fail_r <= 1'b0;
         win_r <= 1'b0;
         tog_r <= 1'b0;
         nrd_r <= 2'd0;
         failseen_r <= 1'b0;
         rstcmd_r <= 1'b0;
         prdata <= 32'h0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         addr_r <= addr_nxt;
         wdat_r <= wdat_nxt;
         rdat_r <= rdat_nxt;
         wr_r <= wr_nxt;
         poll_r <= poll_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
         fail_r <= fail_nxt;
         win_r <= win_nxt;
         tog_r <= tog_nxt;
         nrd_r <= nrd_nxt;
         failseen_r <= failseen_nxt;
         rstcmd_r <= rstcmd_nxt;
         prdata <= prdata_nxt;
      end
   end

   // Flash pins registered from next state to keep outputs glitch free
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_addr <= '0;
         flash_dq_out <= 8'h00;
         flash_dq_oe <= 1'b0;
         flash_ce_n <= 1'b1;
         flash_oe_n <= 1'b1;
         flash_we_n <= 1'b1;
         pready <= 1'b1;
         pslverr <= 1'b0;
      end else begin
         flash_addr <= addr_nxt;
         flash_dq_out <= wdat_nxt;
         flash_dq_oe <= wr_nxt && (state_nxt != fws_pkg::FWS_IDLE);
         flash_ce_n <= !(state_nxt == fws_pkg::FWS_SETUP || state_nxt == fws_pkg::FWS_STRB
                         || state_nxt == fws_pkg::FWS_HOLD);
         flash_oe_n <= !(state_nxt == fws_pkg::FWS_STRB && !wr_nxt);
         flash_we_n <= !(state_nxt == fws_pkg::FWS_STRB && wr_nxt);
         pready <= 1'b1;
         pslverr <= 1'b0;
      end
   end
endmodule : fws_ctrl
`default_nettype wire

/* tb/fws_ctrl_monitor.sv */
// Purpose: Flash bus timing checks for fws_ctrl
// Assumes: Each bus phase is four pclk cycles
// Notes:   Watches flash pins only
`timescale 1ns/100ps
`default_nettype none
module fws_ctrl_monitor #(parameter int AW = 17) (
   input wire logic          pclk,
   input wire logic          presetn,
   input wire logic [AW-1:0] flash_addr,
   input wire logic [7:0]    flash_dq_out,
   input wire logic          flash_dq_oe,
   input wire logic          flash_ce_n,
   input wire logic          flash_oe_n,
   input wire logic          flash_we_n
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Strobes only inside a chip-enable frame
   a_read_framed: assert property (!flash_oe_n |-> !flash_ce_n && !flash_dq_oe)
      else $error("read strobe outside frame or bus driven");
   a_write_framed: assert property (!flash_we_n |-> !flash_ce_n && flash_dq_oe)
      else $error("write strobe outside frame or bus idle");
   // Phase lengths, so the device sees full setup and hold
   a_ce_setup: assert property ($fell(flash_ce_n) |->
      (flash_oe_n && flash_we_n)[*4] ##1 !(flash_oe_n && flash_we_n))
      else $error("strobe setup wrong");
   a_oe_width: assert property ($fell(flash_oe_n) |-> (!flash_oe_n)[*4] ##1 flash_oe_n)
      else $error("read strobe width wrong");
   a_we_width: assert property ($fell(flash_we_n) |-> (!flash_we_n)[*4] ##1 flash_we_n)
      else $error("write strobe width wrong");
   a_ce_hold: assert property ($rose(flash_oe_n) || $rose(flash_we_n) |->
      (!flash_ce_n)[*4] ##1 flash_ce_n)
      else $error("frame hold wrong");
   // Address must not move inside a frame, write data not while the write strobe is low
   a_addr_hold: assert property (!flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr))
      else $error("address moved in frame");
   a_data_hold: assert property (!flash_we_n |-> $stable(flash_dq_out))
      else $error("write data moved");
endmodule : fws_ctrl_monitor
bind fws_ctrl fws_ctrl_monitor #(.AW(AW)) u_mon (.pclk(pclk), .presetn(presetn),
   .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
   .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));
`default_nettype wire

/* tb/fws_flash_model.sv */
// Purpose: Behavioural flash answering status reads
// Assumes: Active-low strobes, no pull on data lines
// Notes:   busy_reads sets how many reads an operation lasts, win_reads
//          how many reads the erase window stays open first
`timescale 1ns/100ps
`default_nettype none
module fws_flash_model #(parameter logic [7:0] ARR = 8'h5a) (
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic [16:0] addr,
   input  wire logic [7:0]  dq_o,
   output logic      [7:0]  dq_i,
   input  wire logic [7:0]  busy_reads,
   input  wire logic [7:0]  win_reads,
   input  wire logic        fail_in,
   output logic      [7:0]  last_wr
);
   logic [7:0] busy = 8'h00;
   logic [7:0] wcnt = 8'h00;
   logic [2:0] esec = 3'h0;
   logic       susp = 1'b0;
   logic       tgl  = 1'b0;
   logic       fl   = 1'b0;
   logic       wopen;
   logic [7:0] val;
   // Erase window open while its reads are not used up
   assign wopen = (wcnt != 8'h00);
   // Array data when idle or outside the suspended sector, else status
   assign val = (busy == 8'h00 || (susp && addr[16:14] != esec)) ? ARR
              : susp ? {1'b1, tgl, 1'b0, 5'h00}
              : {~ARR[7], tgl, fl, 1'b0, !wopen, 3'h0};
   // Released bus shows the inverse, never a stale byte
   assign dq_i = (!ce_n && !oe_n) ? val : ~val;
   // A read ends on whichever strobe rises first; frozen while suspended
   always @(posedge oe_n or posedge ce_n)
      if ((!ce_n || !oe_n) && busy != 8'h00 && !susp) begin
         if (wopen)
            wcnt = wcnt - 8'h01;
         else
            busy = busy - 8'h01;
         tgl = ~tgl;
      end
   // Reset ends all work; while busy only suspend and window commands count
   always @(posedge we_n)
      if (!ce_n) begin
         last_wr = dq_o;
         if (dq_o == 8'hf0) begin
            busy = 8'h00;
            wcnt = 8'h00;
            susp = 1'b0;
            fl = 1'b0;
            tgl = 1'b0;
         end else if (busy == 8'h00) begin
            busy = busy_reads;
            wcnt = win_reads;
            esec = addr[16:14];
            fl = fail_in;
            tgl = 1'b0;
         end else if (dq_o == 8'hb0) begin
            susp = 1'b1;
         end else if (wopen) begin
            wcnt = win_reads;
         end
      end
endmodule : fws_flash_model
`default_nettype wire

/* tb/testbench.sv */
// Purpose: APB driven checks of the flash status poller
// Assumes: Zero-wait APB slave
// Notes:   Flash side is a behavioural model
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00, busy_reads = 8'h00, win_reads = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, slverr, dq_oe, ce_n, oe_n, we_n, fail_in = 1'b0;
   logic [16:0] faddr;
   logic [7:0]  dq_in, dq_out, wr_seen;
   int          err_count = 0, tests_run = 0, cyc = 0;
   always #12.5 pclk = ~pclk;
   fws_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(slverr), .flash_addr(faddr), .flash_dq_in(dq_in), .flash_dq_out(dq_out),
      .flash_dq_oe(dq_oe), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n));
   fws_flash_model mem (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(faddr), .dq_o(dq_out),
      .dq_i(dq_in), .busy_reads(busy_reads), .win_reads(win_reads), .fail_in(fail_in),
      .last_wr(wr_seen));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check
   // One APB transfer; idle edge first so strobes never bounce
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Start, poll busy; a sequencer that never goes idle counts as a mismatch
   task automatic run(input logic [7:0] ctrl);
      int n;
      apb(1'b1, fws_pkg::OFS_CTRL, {24'h0, ctrl});
      n = 0;
      do begin
         apb(1'b0, fws_pkg::OFS_STATUS, 32'h0);
         n++;
      end while (rd[fws_pkg::ST_BUSY] !== 1'b0 && n < 400);
      check("busy", rd & 32'h1, 32'h0);
   endtask : run
   // Run, then compare status; data byte skipped on failure
   task automatic op(input logic [7:0] ctrl, input logic [7:0] d, input logic f);
      logic [31:0] m;
      run(ctrl);
      m = f ? 32'h7 : 32'hff07;
      check("status", rd & m, ({16'h0, d, 8'h0} & m) | {29'h0, f, 2'b10});
   endtask : op
   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : conclude
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         conclude();
      end
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, fws_pkg::OFS_STATUS, 32'h0);
      check("idle busy", rd & 32'h1, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      check("unmapped", rd, 32'h0);
      apb(1'b1, fws_pkg::OFS_ADDR, 32'h00123);
      op(8'h01, 8'h5a, 1'b0);
      $display("test plain read done");
      busy_reads <= 8'h03;
      apb(1'b1, fws_pkg::OFS_DATA, 32'h3c);
      op(8'h07, 8'h5a, 1'b0);
      check("written byte", {24'h0, wr_seen}, 32'h3c);
      $display("test program poll done");
      busy_reads <= 8'h02;
      fail_in <= 1'b1;
      op(8'h07, 8'h5a, 1'b0);
      $display("test late stop done");
      busy_reads <= 8'hff;
      op(8'h07, 8'h00, 1'b1);
      check("reset byte", {24'h0, wr_seen}, 32'hf0);
      $display("test failure done");
      busy_reads <= 8'h02;
      win_reads <= 8'h02;
      fail_in <= 1'b0;
      apb(1'b1, fws_pkg::OFS_DATA, 32'h30);
      run(8'h03);
      op(8'h01, 8'h80, 1'b0);
      run(8'h03);
      op(8'h01, 8'hc0, 1'b0);
      op(8'h01, 8'h80, 1'b0);
      run(8'h03);
      op(8'h01, 8'hc8, 1'b0);
      op(8'h05, 8'h5a, 1'b0);
      $display("test erase window done");
      busy_reads <= 8'hff;
      win_reads <= 8'h00;
      apb(1'b1, fws_pkg::OFS_ADDR, 32'h04000);
      run(8'h03);
      apb(1'b1, fws_pkg::OFS_DATA, 32'hb0);
      run(8'h03);
      op(8'h05, 8'h80, 1'b0);
      apb(1'b1, fws_pkg::OFS_ADDR, 32'h00123);
      op(8'h01, 8'h5a, 1'b0);
      check("flash address", {15'h0, faddr}, 32'h123);
      check("slave error", {31'h0, slverr}, 32'h0);
      $display("test suspend done");
      conclude();
   end
endmodule : testbench
`default_nettype wire
